// ---- ads_supervisor.sv ----
// Notes on behaviour
// - Regulator overtemp sets warning flag and interrupt
// - Warning flag follows condition while present
// - No regulator warning in sleep or stop
// - Any switch overtemp kills all, flags, interrupts
// - Switch shutdown flag follows condition while present
// - No switch shutdown detection in sleep/stop
// - Switches one/two need enable and PWM high
// - Switch overtemp latches all three switches off
// - Low-power modes force all switches off
// - Switch three needs its enable, ignores PWM
// - Slew from field, reset gives 20k
// - Transmitter enabled only normal and normal-request
// - Bus driver fault shuts transmitter, sets flag
// - Pull-up disconnect bit applies in low power
// - Transmit low drives bus dominant
// - Undriven transmit input reads recessive high
// - Receive output mirrors bus level
// - Low power keeps receiver, disables transmitter
// - Stop wake: long dominant, edge, interrupt
// - Sleep wake: long dominant, edge, reset
// - Watchdog clear outside open window resets
// - First clear unwindowed; grounded pin disables
// - Mode field: sleep, stop, clear, run
// - Slew field: 20k, 10k, 100k, low-power
// - Events pulse interrupt; source bit read-once
module ads_supervisor
  import ads_pkg::*;
#(
  parameter int WD_CYC   = ads_pkg::WD_PERIOD_CYC,
  parameter int WAKE_CYC = ads_pkg::WAKE_MIN_CYC
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [1:0] operating_mode_field,
  input  wire logic [1:0] bus_slew_select_field,
  input  wire logic       bus_pullup_disconnect_bit,
  input  wire logic       switch_one_enable_bit,
  input  wire logic       switch_two_enable_bit,
  input  wire logic       switch_three_enable_bit,
  input  wire logic       ctrl_write,
  input  wire logic       status_read,
  input  wire logic       pwm_gate_input,
  input  wire logic       txd_in,
  input  wire logic       txd_driven,
  input  wire logic       bus_level_in,
  input  wire logic       reg_overtemp_in,
  input  wire logic       switch_overtemp_in,
  input  wire logic       bus_driver_fault_in,
  input  wire logic       watchdog_period_config_pin,
  output logic            switch_output_one,
  output logic            switch_output_two,
  output logic            switch_output_three,
  output logic [1:0]      bus_slew_rate,
  output logic            bus_tx_enable,
  output logic            bus_drive_low,
  output logic            bus_pullup_connect,
  output logic            bus_current_source_on,
  output logic            rxd_out,
  output logic            irq_n,
  output logic            rst_out_n,
  output logic [7:0]      status_word,
  output logic            regulator_overtemp_warning_flag,
  output logic            switch_thermal_shutdown_flag,
  output logic            bus_driver_fault_flag,
  output logic            bus_wake_flag,
  output logic            irq_source_valid_bit
);
  import ads_pkg::*;

  // Pin inputs are asynchronous; analog faults too
  localparam int NS = 8;
  logic [NS-1:0] sync_q;
  logic          pwm_s, txd_s, txdrv_s, bus_s, vt_s, ht_s, lf_s, wdc_s;
  logic          txd_n_s, bus_n_s;

  ads_sync #(.W(NS)) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .din  ({pwm_gate_input, ~txd_in, txd_driven, ~bus_level_in,
            reg_overtemp_in, switch_overtemp_in, bus_driver_fault_in,
            watchdog_period_config_pin}),
    .dout (sync_q)
  );
  assign {pwm_s, txd_n_s, txdrv_s, bus_n_s, vt_s, ht_s, lf_s, wdc_s} = sync_q;
  // Idle-high pins cross inverted, so reset reads recessive, no false edge
  assign txd_s = !txd_n_s;
  assign bus_s = !bus_n_s;

  typedef struct packed {
    ads_mode_e            mode;
    logic [CNT_W-1:0]     wd_cnt;
    logic                 wd_open;
    logic [CNT_W-1:0]     dom_cnt;
    logic                 dom_long;
    logic [7:0]           irq_cnt;
    logic [7:0]           rst_cnt;
    logic [1:0]           lp_cnt;
    logic                 vt_q, ht_q, lf_q;
    logic                 hs_latch;
    logic                 hs1, hs2, hs3;
    logic [1:0]           slew;
    logic                 pu_disc;
    logic                 txen, drive_low, rxd;
    logic                 cs_on, pu_con;
    logic                 vflag, hflag, lflag, wflag;
    logic                 src;
    logic [6:0]           src_bits;
    logic                 irq_n, rst_n;
    logic [7:0]           stat;
  } ads_state_s;

  ads_state_s st, next_st;

  // Half window boundary for the closed/open split
  function automatic logic [CNT_W-1:0] half_of(input int v);
    half_of = CNT_W'(v / 2);
  endfunction

  function automatic logic low_power(input ads_mode_e m);
    low_power = (m == ADS_STOP) || (m == ADS_SLEEP);
  endfunction

  logic lp, wd_on, clr_req, lp_req, ev, rise, fault_evt;
  logic tx_level;

  always_comb
  begin
    next_st   = st;
    lp        = low_power(st.mode);
    wd_on     = wdc_s;
    clr_req   = ctrl_write && (operating_mode_field == MODE_WD_CLR);
    lp_req    = ctrl_write && (bus_slew_select_field == SLEW_LP_REQ)
                && !operating_mode_field[1];
    ev        = 1'b0;
    fault_evt = 1'b0;
    rise      = bus_s && !st.rxd;
    // Undriven input reads as recessive
    tx_level  = txdrv_s ? txd_s : 1'b1;

    // Mode control; reset state leaves after the pulse
    case (st.mode)
      ADS_RESET:    if (st.rst_cnt == 8'h00) next_st.mode = ADS_NORM_REQ;
      ADS_NORM_REQ, ADS_RUN:
      begin
        if (ctrl_write && operating_mode_field == MODE_RUN && st.mode == ADS_RUN)
          next_st.mode = ADS_RUN;
        // Low-power needs two low-power requests in a row against noise
        if (lp_req)
        begin
          next_st.lp_cnt = st.lp_cnt + 2'h1;
          if (st.lp_cnt != 2'h0)
            next_st.mode = (operating_mode_field == MODE_SLEEP) ? ADS_SLEEP
                                                                : ADS_STOP;
        end
        else if (ctrl_write)
          next_st.lp_cnt = 2'h0;
      end
      ADS_STOP, ADS_SLEEP: next_st.lp_cnt = 2'h0;
      default:      next_st.mode = ADS_RESET;
    endcase

    // Window watchdog: closed half then open half
    if (st.mode == ADS_NORM_REQ || st.mode == ADS_RUN)
    begin
      next_st.wd_cnt = st.wd_cnt + CNT_W'(1);
      if (st.mode == ADS_RUN && st.wd_cnt >= half_of(WD_CYC))
        next_st.wd_open = 1'b1;
      if (wd_on && clr_req)
      begin
        if (st.mode == ADS_NORM_REQ || st.wd_open)
        begin
          next_st.mode    = ADS_RUN;
          next_st.wd_cnt  = '0;
          next_st.wd_open = 1'b0;
        end
        else
          next_st.mode = ADS_RESET;
      end
      else if (wd_on && st.wd_cnt >= CNT_W'(WD_CYC - 1))
        next_st.mode = ADS_RESET;
      else if (!wd_on && clr_req)
        next_st.mode = ADS_RUN;
    end
    else
    begin
      next_st.wd_cnt  = '0;
      next_st.wd_open = 1'b0;
    end

    // Thermal faults masked in low power; driver fault is not
    next_st.vt_q  = vt_s && !lp;
    next_st.ht_q  = ht_s && !lp;
    next_st.lf_q  = lf_s;
    next_st.vflag = vt_s && !lp;
    next_st.hflag = ht_s && !lp;
    next_st.lflag = lf_s;
    if (next_st.vt_q && !st.vt_q)
      fault_evt = 1'b1;
    if (next_st.ht_q && !st.ht_q)
    begin
      fault_evt        = 1'b1;
      next_st.hs_latch = 1'b1;
    end
    if (lf_s && !st.lf_q)
      fault_evt = 1'b1;
    // Latch released by a control write once overtemp clears, or by reset
    if (ctrl_write && !ht_s)
      next_st.hs_latch = 1'b0;

    // Switch gating
    next_st.hs1 = switch_one_enable_bit && pwm_s && !st.hs_latch && !ht_s && !lp;
    next_st.hs2 = switch_two_enable_bit && pwm_s && !st.hs_latch && !ht_s && !lp;
    next_st.hs3 = switch_three_enable_bit && !st.hs_latch && !ht_s && !lp;

    // Bus physical layer
    if (ctrl_write && bus_slew_select_field != SLEW_LP_REQ)
      next_st.slew = bus_slew_select_field;
    if (ctrl_write)
      next_st.pu_disc = bus_pullup_disconnect_bit;
    // Next mode, so the driver drops on the same edge as reset or stop entry
    next_st.txen      = (next_st.mode == ADS_NORM_REQ || next_st.mode == ADS_RUN) && !lf_s;
    next_st.drive_low = next_st.txen && !tx_level;
    next_st.rxd       = bus_s;

    // Wake detector: long dominant then rising edge
    if (!bus_s)
    begin
      if (st.dom_cnt >= CNT_W'(WAKE_CYC - 1))
        next_st.dom_long = 1'b1;
      else
        next_st.dom_cnt = st.dom_cnt + CNT_W'(1);
    end
    else
    begin
      next_st.dom_cnt  = '0;
      next_st.dom_long = 1'b0;
    end
    if (lp && rise && st.dom_long)
    begin
      next_st.wflag = 1'b1;
      if (st.mode == ADS_STOP)
      begin
        ev           = 1'b1;
        next_st.mode = ADS_RUN;
      end
      else
        next_st.mode = ADS_RESET;
    end

    // Interrupt pulse and read-once source
    if (fault_evt || ev)
    begin
      next_st.irq_cnt  = 8'(IRQ_PULSE_CYC);
      next_st.src      = 1'b1;
      next_st.src_bits = {ev | next_st.lflag, 2'h0, next_st.vflag, next_st.hflag, 2'h0};
    end
    else if (st.irq_cnt != 8'h00)
      next_st.irq_cnt = st.irq_cnt - 8'h01;
    next_st.irq_n = (next_st.irq_cnt == 8'h00);

    // Status word latched for a read; source shown once
    next_st.stat = {1'b0, st.lflag | st.wflag, 2'h0, st.vflag, st.hflag, 2'h0};
    if (st.src)
      next_st.stat = {1'b1, st.src_bits};
    next_st.stat[ST_REGULATOR_OVERTEMP_WARNING_FLAG] = st.vflag | (st.src & st.src_bits[ST_REGULATOR_OVERTEMP_WARNING_FLAG]);
    if (status_read)
    begin
      if (!(fault_evt || ev))
        next_st.src = 1'b0;
      // Wake set wins over a read in the same cycle
      if (!(lp && rise && st.dom_long))
        next_st.wflag = 1'b0;
    end

    // Device reset pulse
    if (next_st.mode == ADS_RESET && st.mode != ADS_RESET)
      next_st.rst_cnt = 8'(RST_PULSE_CYC);
    else if (st.rst_cnt != 8'h00)
      next_st.rst_cnt = st.rst_cnt - 8'h01;
    next_st.rst_n = (next_st.mode != ADS_RESET) && (next_st.mode != ADS_SLEEP);
    if (next_st.mode == ADS_RESET)
    begin
      next_st.hs_latch = 1'b0;
      next_st.slew     = SLEW_20K;
    end

    // Pull-up swap registered so both pins come from flops
    next_st.cs_on  = next_st.pu_disc && low_power(next_st.mode);
    next_st.pu_con = !next_st.cs_on;
  end

  // State register
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      st          <= '0;
      st.mode     <= ADS_RESET;
      st.rst_cnt  <= 8'(RST_PULSE_CYC);
      st.slew     <= SLEW_20K;
      st.irq_n    <= 1'b1;
      st.rxd      <= 1'b1;
      st.pu_con   <= 1'b1;
    end
    else
      st <= next_st;
  end

  // Outputs straight from flops
  assign switch_output_one               = st.hs1;
  assign switch_output_two               = st.hs2;
  assign switch_output_three             = st.hs3;
  assign bus_slew_rate                   = st.slew;
  assign bus_tx_enable                   = st.txen;
  assign bus_drive_low                   = st.drive_low;
  assign bus_current_source_on           = st.cs_on;
  assign bus_pullup_connect              = st.pu_con;
  assign rxd_out                         = st.rxd;
  assign irq_n                           = st.irq_n;
  assign rst_out_n                       = st.rst_n;
  assign status_word                     = st.stat;
  assign regulator_overtemp_warning_flag = st.vflag;
  assign switch_thermal_shutdown_flag    = st.hflag;
  assign bus_driver_fault_flag           = st.lflag;
  assign bus_wake_flag                   = st.wflag;
  assign irq_source_valid_bit            = st.src;
endmodule // ads_supervisor

// ---- ads_pkg.sv ----
package ads_pkg;
  // Mode field codes
  localparam logic [1:0] MODE_SLEEP   = 2'h0;
  localparam logic [1:0] MODE_STOP    = 2'h1;
  localparam logic [1:0] MODE_WD_CLR  = 2'h2;
  localparam logic [1:0] MODE_RUN     = 2'h3;
  // Slew select codes
  localparam logic [1:0] SLEW_20K     = 2'h0;
  localparam logic [1:0] SLEW_10K     = 2'h1;
  localparam logic [1:0] SLEW_100K    = 2'h2;
  localparam logic [1:0] SLEW_LP_REQ  = 2'h3;
  // Clock and timing
  localparam int CLK_HZ               = 25000000;
  localparam int WD_PERIOD_MS         = 150;
  localparam int WD_PERIOD_CYC        = WD_PERIOD_MS * (CLK_HZ / 1000);
  localparam int WAKE_MIN_US          = 150;
  localparam int WAKE_MIN_CYC         = WAKE_MIN_US * (CLK_HZ / 1000000);
  localparam int IRQ_PULSE_CYC        = 4;
  localparam int RST_PULSE_CYC        = 16;
  localparam int CNT_W                = 32;
  // Status word bit positions
  localparam int ST_SRC               = 7;
  localparam int ST_LIN               = 6;
  localparam int ST_REGULATOR_OVERTEMP_WARNING_FLAG              = 3;
  localparam int ST_SWITCH_THERMAL_SHUTDOWN_FLAG              = 2;

  // Operating states, one-hot
  typedef enum logic [4:0] {
    ADS_RESET    = 5'h01,
    ADS_NORM_REQ = 5'h02,
    ADS_RUN      = 5'h04,
    ADS_STOP     = 5'h08,
    ADS_SLEEP    = 5'h10
  } ads_mode_e;
endpackage : ads_pkg

// ---- ads_sync.sv ----
// Two-flop synchroniser bank for asynchronous analog indications
module ads_sync #(
  parameter int W = 4
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic [W-1:0]      dout
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } ads_sync_s;

  ads_sync_s st, next_st;

  // First stage feeds only the second
  always_comb
  begin
    next_st      = st;
    next_st.meta = din;
    next_st.q    = st.meta;
  end

  // Resets to zero; callers invert idle-high pins
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign dout = st.q;
endmodule // ads_sync

// ---- ads_bus_model.sv ----
// Far side of the bus pin: the supervisor's driver plus one remote node
module ads_bus_model
(
  input  wire logic bus_drive_low,
  input  wire logic ext_dominant,
  output logic      bus_level
);
  timeunit 1ns;
  timeprecision 1ns;
  // Wired-AND line with pull-up, so a released line reads recessive
  assign bus_level = !(bus_drive_low || ext_dominant);
endmodule // ads_bus_model

// ---- ads_supervisor_sva.sv ----
// Port-level checks on the supervisor; pin latency is sync plus one register
module ads_supervisor_sva
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic status_read,
  input wire logic pwm_gate_input,
  input wire logic txd_in,
  input wire logic txd_driven,
  input wire logic bus_level_in,
  input wire logic switch_output_one,
  input wire logic switch_output_two,
  input wire logic switch_output_three,
  input wire logic bus_tx_enable,
  input wire logic bus_drive_low,
  input wire logic bus_pullup_connect,
  input wire logic bus_current_source_on,
  input wire logic rxd_out,
  input wire logic irq_n,
  input wire logic rst_out_n,
  input wire logic switch_thermal_shutdown_flag,
  input wire logic bus_driver_fault_flag,
  input wire logic irq_source_valid_bit
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // Interrupt pulse is exactly four low cycles
  sequence s_irq_low;
    !irq_n [*4];
  endsequence
  sequence s_all_off;
    !switch_output_one && !switch_output_two && !switch_output_three;
  endsequence
  a_irq_pulse_len: assert property ($fell(irq_n) |-> s_irq_low ##1 irq_n)
    else $error("interrupt pulse length wrong");
  a_irq_src_set: assert property ($fell(irq_n) |-> ##[0:2] irq_source_valid_bit)
    else $error("source bit missing after interrupt");
  a_src_read_once: assert property (status_read && irq_source_valid_bit && irq_n
    |=> !irq_source_valid_bit || $fell(irq_n))
    else $error("source bit survived a read");
  a_switch_thermal_shutdown_flag_all_off: assert property ($rose(switch_thermal_shutdown_flag) |-> ##[0:1] s_all_off)
    else $error("switches on after thermal shutdown");
  a_switch_thermal_shutdown_flag_latch_off: assert property ($fell(switch_thermal_shutdown_flag) |-> s_all_off)
    else $error("switches returned when fault cleared");
  a_pwm_gate_one: assert property (switch_output_one |-> $past(pwm_gate_input, 3))
    else $error("switch one on without gate");
  a_pwm_gate_two: assert property (switch_output_two |-> $past(pwm_gate_input, 3))
    else $error("switch two on without gate");
  a_txd_dominant: assert property (bus_drive_low |-> bus_tx_enable && $past(txd_driven, 3)
    && !$past(txd_in, 3))
    else $error("bus driven dominant without cause");
  a_rxd_mirror: assert property ($changed(rxd_out) |-> rxd_out == $past(bus_level_in, 3))
    else $error("receive output does not follow bus");
  a_pullup_swap: assert property (bus_pullup_connect != bus_current_source_on)
    else $error("pull-up and current source disagree");
  a_fault_tx_off: assert property (bus_driver_fault_flag |-> !bus_tx_enable)
    else $error("transmitter on during driver fault");
  a_reset_tx_off: assert property (!rst_out_n |-> !bus_tx_enable && !bus_drive_low)
    else $error("transmitter on during reset");
  a_csrc_low_power: assert property (bus_current_source_on |-> !bus_tx_enable)
    else $error("current source on outside low power");
endmodule // ads_supervisor_sva

bind ads_supervisor ads_supervisor_sva u_ads_supervisor_sva (.mclk(mclk), .rst(rst),
  .status_read(status_read), .pwm_gate_input(pwm_gate_input), .txd_in(txd_in), .txd_driven(txd_driven),
  .bus_level_in(bus_level_in), .switch_output_one(switch_output_one), .switch_output_two(switch_output_two),
  .switch_output_three(switch_output_three), .bus_tx_enable(bus_tx_enable), .bus_drive_low(bus_drive_low),
  .bus_pullup_connect(bus_pullup_connect), .bus_current_source_on(bus_current_source_on), .rxd_out(rxd_out),
  .irq_n(irq_n), .rst_out_n(rst_out_n), .switch_thermal_shutdown_flag(switch_thermal_shutdown_flag),
  .bus_driver_fault_flag(bus_driver_fault_flag), .irq_source_valid_bit(irq_source_valid_bit));

// ---- test_ads_supervisor.sv ----
module test_ads_supervisor;
  import ads_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic       mclk = 0, rst = 1, wr = 0, rd = 0, pu = 0, en1 = 0, en2 = 0, en3 = 0, pwm = 0;
  logic       txd = 1, txdv = 1, reg_ot = 0, sw_ot = 0, fault = 0, wdp = 0, ext_dom = 0;
  logic [1:0] mode = MODE_RUN, slew = SLEW_20K, sr;
  logic       o1, o2, o3, txe, dl, puc, cs, rxd, irq_n, rsto_n, rf, sf, lf, wf, src;
  logic [7:0] sw;
  wire logic  bus_lvl;
  int         n_fail = 0, cmp_count = 0, base = 0, ev[3] = '{0, 0, 0};

  always #20 mclk = ~mclk;
  // Edge counters let waits see short pulses without polling in the same step
  always @(negedge irq_n) ev[0]++;
  always @(negedge rsto_n) ev[1]++;
  always @(posedge rsto_n) ev[2]++;

  // Short watchdog and wake times keep the run brief
  ads_supervisor #(.WD_CYC(200), .WAKE_CYC(10)) u_ads_supervisor (.mclk(mclk), .rst(rst),
    .operating_mode_field(mode), .bus_slew_select_field(slew), .bus_pullup_disconnect_bit(pu),
    .switch_one_enable_bit(en1), .switch_two_enable_bit(en2), .switch_three_enable_bit(en3),
    .ctrl_write(wr), .status_read(rd), .pwm_gate_input(pwm), .txd_in(txd), .txd_driven(txdv),
    .bus_level_in(bus_lvl), .reg_overtemp_in(reg_ot), .switch_overtemp_in(sw_ot),
    .bus_driver_fault_in(fault), .watchdog_period_config_pin(wdp), .switch_output_one(o1),
    .switch_output_two(o2), .switch_output_three(o3), .bus_slew_rate(sr), .bus_tx_enable(txe),
    .bus_drive_low(dl), .bus_pullup_connect(puc), .bus_current_source_on(cs), .rxd_out(rxd),
    .irq_n(irq_n), .rst_out_n(rsto_n), .status_word(sw), .regulator_overtemp_warning_flag(rf),
    .switch_thermal_shutdown_flag(sf), .bus_driver_fault_flag(lf), .bus_wake_flag(wf),
    .irq_source_valid_bit(src));
  ads_bus_model u_ads_bus_model (.bus_drive_low(dl), .ext_dominant(ext_dom), .bus_level(bus_lvl));

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      n_fail++;
    end
  endtask

  // Inputs change one time unit after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // One control write, then settle time for the synchronised outputs
  task automatic put(input logic [1:0] m, input logic [1:0] s);
    mode = m;
    slew = s;
    wr = 1;
    tick(1);
    wr = 0;
    tick(6);
  endtask

  task automatic read();
    rd = 1;
    tick(1);
    rd = 0;
    tick(1);
  endtask

  // Bounded wait for counter i to move past base
  task automatic wait_ev(input int i, input int lim);
    for (int k = 0; k < lim && ev[i] == base; k++)
      tick(1);
    if (ev[i] == base)
    begin
      n_fail++;
      print_verdict();
    end
  endtask

  initial
  begin
    tick(20);
    rst = 0;
    wait_ev(2, 40);
    chk(8'({sr, txe, rxd}), 8'h03);
    for (int s = 0; s < 4; s++)
    begin
      if (s < 3) put(MODE_RUN, 2'(s));
      if (s < 3) chk(8'(sr), 8'(s));
    end
    en1 = 1; en2 = 1; en3 = 1; pwm = 1; tick(6);
    chk(8'({o1, o2, o3}), 8'h07);
    pwm = 0; tick(6);
    chk(8'({o1, o2, o3}), 8'h01);
    en3 = 0; en1 = 0; pwm = 1; tick(6);
    chk(8'({o1, o2, o3}), 8'h02);
    en3 = 1; en1 = 1; txd = 0; tick(6);
    chk(8'({dl, rxd}), 8'h02);
    txdv = 0; tick(6); // Undriven input must read recessive
    chk(8'(dl), 8'h00);
    txdv = 1; txd = 1; tick(6);
    chk(8'(rxd), 8'h01);
    base = ev[0]; reg_ot = 1; wait_ev(0, 20); tick(40);
    chk(8'({rf, sw[ST_REGULATOR_OVERTEMP_WARNING_FLAG], src}), 8'h07);
    read();
    chk(8'(src), 8'h00);
    reg_ot = 0; tick(6);
    chk(8'(rf), 8'h00);
    base = ev[0]; sw_ot = 1; wait_ev(0, 20); tick(2);
    chk(8'({sf, o1, o2, o3}), 8'h08);
    sw_ot = 0; tick(6);
    chk(8'({sf, o1, o2, o3}), 8'h00);
    put(MODE_RUN, SLEW_20K);
    chk(8'({o1, o2, o3}), 8'h07);
    read();
    fault = 1; tick(6);
    chk(8'({lf, txe}), 8'h02);
    fault = 0; tick(6); read();
    // Stop entry needs the request twice; enables stay high on purpose
    pu = 1; put(MODE_STOP, SLEW_LP_REQ); put(MODE_STOP, SLEW_LP_REQ);
    reg_ot = 1; sw_ot = 1; tick(10);
    chk({txe, o1, o2, o3, puc, cs, rf, sf}, 8'h04);
    reg_ot = 0; sw_ot = 0; tick(6);
    base = ev[0]; ext_dom = 1; tick(4); ext_dom = 0; tick(20);
    chk(8'(ev[0] - base), 8'h00);
    ext_dom = 1; tick(15);
    chk(8'(rxd), 8'h00);
    ext_dom = 0; wait_ev(0, 20); tick(6);
    chk(8'(wf), 8'h01);
    read(); pu = 0;
    put(MODE_SLEEP, SLEW_LP_REQ); put(MODE_SLEEP, SLEW_LP_REQ);
    base = ev[2]; ext_dom = 1; tick(15); ext_dom = 0; wait_ev(2, 60); tick(2);
    chk(8'(wf), 8'h01);
    // Watchdog armed by the pin, then a second reset in mid-run
    wdp = 1; rst = 1; tick(2); rst = 0; base = ev[2]; wait_ev(2, 40);
    base = ev[1]; put(MODE_WD_CLR, SLEW_20K); tick(130);
    put(MODE_WD_CLR, SLEW_20K); tick(20);
    chk(8'(ev[1] - base), 8'h00);
    put(MODE_WD_CLR, SLEW_20K); wait_ev(1, 20);
    base = ev[2]; wait_ev(2, 40); base = ev[1]; tick(150);
    chk(8'(ev[1] - base), 8'h00);
    wait_ev(1, 100);
    // Run mode with no clear by the end of the open window
    base = ev[2]; wait_ev(2, 40);
    put(MODE_WD_CLR, SLEW_20K); base = ev[1]; tick(150);
    chk(8'(ev[1] - base), 8'h00);
    wait_ev(1, 100);
    print_verdict();
  end
endmodule // test_ads_supervisor
